/* File: hw/wdsc_top.sv */
// Watchdog counter with its control register and the system control register
//
// How it works
// - 16-bit up counter, overflow resets device
// - Time base taken from oscillator clock
// - Idle until enable bit 7 written 1
// - Bits 2..0 divide by 8 to 1024
// - Timeout is 65536 divided-clock periods
// - Any reset returns enable bit to 0
// - Writing clear bit 5 restarts from zero
// - Overflow sets status bit 7 of system control
// - Emission bit 0 suppresses oscillator/6 strobe output
`timescale 1ns/10ps
`default_nettype none
`include "wdsc_cfg.svh"

module wdsc_top #(
    parameter logic [15:0] WDT_LAST = `WDSC_CNT_LAST
) (
    input  wire logic                   clk,
    input  wire logic                   nrst,
    input  wire wdsc_pkg::wdsc_sfr_req_t sfr_req,
    output var  logic [7:0]             sfr_rdata,
    output var  logic                   wdt_reset,
    output var  logic                   ale_clk,
    output var  logic [15:0]            wdt_count
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic                enable_ff;
    wdsc_pkg::wdsc_div_t div_ff;
    logic [15:0]         cnt_ff;
    logic                status_ff;
    logic                emi_ff;
    logic                wdt_reset_ff;
    logic [7:0]          rdata_ff;
    logic [1:0]          ale_cnt_ff;
    logic                ale_phase_ff;
    logic                ale_out_ff;
    logic [1:0]          rst_sync_ff;
    logic                nrst_sync;

    logic                wr_wdc;
    logic                wr_sys;
    logic                clr_req;
    logic                tick;
    logic                overflow;
    logic [7:0]          wdc_view;
    logic [7:0]          sys_view;

    assign wr_wdc  = sfr_req.wr &&
                     (sfr_req.addr == `WDSC_WATCHDOG_CONTROL_ADDR);
    assign wr_sys  = sfr_req.wr &&
                     (sfr_req.addr == `WDSC_SYSTEM_CONTROL_ADDR);
    assign clr_req = wr_wdc && sfr_req.wdata[`WDSC_WDC_CLEAR_BIT];

    // overflow when the last count ticks
    assign overflow = enable_ff && tick && (cnt_ff == WDT_LAST);

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    // Pin reset takes hold at once but lets go through two flops, so no
    // register leaves reset on an edge that the pin may have straddled
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end

    assign nrst_sync = rst_sync_ff[1];

    // ------------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------------
    // Held cleared while idle or restarting, so each restart gets a
    // full first period rather than a partial one
    wdsc_prescaler u_pre (
        .clk     (clk),
        .nrst    (nrst_sync),
        .run     (enable_ff && !clr_req && !overflow),
        .div_sel (div_ff),
        .tick    (tick)
    );

    // ------------------------------------------------------------------
    // Watchdog control register
    // ------------------------------------------------------------------
    // enable cleared by either reset
    always_ff @(posedge clk or negedge nrst_sync) begin
        if (!nrst_sync) begin
            enable_ff <= 1'b0;
        end else if (overflow) begin
            enable_ff <= 1'b0;
        end else if (wr_wdc) begin
            enable_ff <= sfr_req.wdata[`WDSC_WDC_ENABLE_BIT];
        end
    end

    // Divider also returns to its reset code on a watchdog reset
    always_ff @(posedge clk or negedge nrst_sync) begin
        if (!nrst_sync) begin
            div_ff <= `WDSC_DIV_RST;
        end else if (overflow) begin
            div_ff <= `WDSC_DIV_RST;
        end else if (wr_wdc) begin
            div_ff <= sfr_req.wdata[`WDSC_WDC_DIV_MSB:`WDSC_WDC_DIV_LSB];
        end
    end

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst_sync) begin
        if (!nrst_sync) begin
            cnt_ff <= `WDSC_CNT_RST;
        end else if (clr_req || overflow || !enable_ff) begin
            cnt_ff <= `WDSC_CNT_RST;
        end else if (tick) begin
            cnt_ff <= cnt_ff + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge nrst_sync) begin
        if (!nrst_sync) begin
            wdt_reset_ff <= 1'b0;
        end else begin
            wdt_reset_ff <= overflow;
        end
    end

    // ------------------------------------------------------------------
    // System control register
    // ------------------------------------------------------------------
    // pin reset clears it, as does a write with status bit 7 at 0
    always_ff @(posedge clk or negedge nrst_sync) begin
        if (!nrst_sync) begin
            status_ff <= 1'b0;
        end else if (overflow) begin
            status_ff <= 1'b1;
        end else if (wr_sys && !sfr_req.wdata[`WDSC_SYS_STATUS_BIT]) begin
            status_ff <= 1'b0;
        end
    end

    // Emission setting is left alone by a watchdog reset
    always_ff @(posedge clk or negedge nrst_sync) begin
        if (!nrst_sync) begin
            emi_ff <= 1'b0;
        end else if (wr_sys) begin
            emi_ff <= sfr_req.wdata[`WDSC_SYS_EMI_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Oscillator/6 strobe
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst_sync) begin
        if (!nrst_sync) begin
            ale_cnt_ff   <= 2'h0;
            ale_phase_ff <= 1'b0;
        end else if (ale_cnt_ff == `WDSC_ALE_HALF_LAST) begin
            ale_cnt_ff   <= 2'h0;
            ale_phase_ff <= !ale_phase_ff;
        end else begin
            ale_cnt_ff   <= ale_cnt_ff + 2'h1;
        end
    end

    always_ff @(posedge clk or negedge nrst_sync) begin
        if (!nrst_sync) begin
            ale_out_ff <= 1'b0;
        end else begin
            ale_out_ff <= ale_phase_ff && !emi_ff;
        end
    end

    // ------------------------------------------------------------------
    // Read back
    // ------------------------------------------------------------------
    // clear reads 0, unused zero
    always_comb begin
        wdc_view = 8'h00;
        wdc_view[`WDSC_WDC_ENABLE_BIT] = enable_ff;
        wdc_view[`WDSC_WDC_DIV_MSB:`WDSC_WDC_DIV_LSB] = div_ff;
        sys_view = 8'h00;
        sys_view[`WDSC_SYS_STATUS_BIT] = status_ff;
        sys_view[`WDSC_SYS_EMI_BIT] = emi_ff;
    end

    // Unmapped addresses read 0; data held between reads
    always_ff @(posedge clk or negedge nrst_sync) begin
        if (!nrst_sync) begin
            rdata_ff <= `WDSC_RDATA_RST;
        end else if (sfr_req.rd) begin
            case (sfr_req.addr)
                `WDSC_WATCHDOG_CONTROL_ADDR: rdata_ff <= wdc_view;
                `WDSC_SYSTEM_CONTROL_ADDR:   rdata_ff <= sys_view;
                default:                     rdata_ff <= 8'h00;
            endcase
        end
    end

    assign sfr_rdata = rdata_ff;
    assign wdt_reset = wdt_reset_ff;
    assign ale_clk   = ale_out_ff;
    assign wdt_count = cnt_ff;

endmodule // wdsc_top

`default_nettype wire

/* File: hw/wdsc_cfg.svh */
// Offsets, field positions, reset values and timing counts of the watchdog
`ifndef WDSC_CFG_SVH
`define WDSC_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define WDSC_SYSTEM_CONTROL_ADDR   8'hBF
`define WDSC_WATCHDOG_CONTROL_ADDR 8'hD8

// ----------------------------------------------------------------------
// Watchdog control fields
// ----------------------------------------------------------------------
`define WDSC_WDC_ENABLE_BIT        7
`define WDSC_WDC_CLEAR_BIT         5
`define WDSC_WDC_DIV_MSB           2
`define WDSC_WDC_DIV_LSB           0

// ----------------------------------------------------------------------
// System control fields
// ----------------------------------------------------------------------
`define WDSC_SYS_STATUS_BIT        7
`define WDSC_SYS_EMI_BIT           0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define WDSC_DIV_RST               3'h0
`define WDSC_CNT_RST               16'h0000
`define WDSC_RDATA_RST             8'h00

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define WDSC_CNT_LAST              16'hFFFF
`define WDSC_PRE_WIDTH             10
`define WDSC_PRE_MASK_ALL          10'h3FF
`define WDSC_PRE_MIN_BITS          3
`define WDSC_DIV_TOP               3'h7
`define WDSC_ALE_HALF_LAST         2'h2

`endif

/* File: hw/wdsc_pkg.sv */
// Types shared by the watchdog and system control block
`default_nettype none

package wdsc_pkg;

    // Special-function register access from the core, oscillator clocked
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } wdsc_sfr_req_t;

    typedef logic [2:0] wdsc_div_t;

endpackage : wdsc_pkg

`default_nettype wire

/* File: hw/wdsc_prescaler.sv */
// Oscillator divider giving one tick per 8 to 1024 oscillator cycles
`timescale 1ns/10ps
`default_nettype none
`include "wdsc_cfg.svh"

module wdsc_prescaler (
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              run,
    input  wire wdsc_pkg::wdsc_div_t div_sel,
    output var  logic              tick
);

    logic [`WDSC_PRE_WIDTH-1:0] pre_ff;
    logic [`WDSC_PRE_WIDTH-1:0] mask;
    logic                       tick_ff;

    // ------------------------------------------------------------------
    // Division select
    // ------------------------------------------------------------------
    // code picks 2**(code+3)
    assign mask = `WDSC_PRE_MASK_ALL >> (`WDSC_DIV_TOP - div_sel);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pre_ff <= '0;
        end else if (!run) begin
            pre_ff <= '0;
        end else begin
            pre_ff <= pre_ff + `WDSC_PRE_WIDTH'(1);
        end
    end

    // Registered so the counter sees a clean single-cycle strobe
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= run && ((pre_ff & mask) == mask);
        end
    end

    assign tick = tick_ff;

endmodule // wdsc_prescaler

`default_nettype wire

/* File: test/wdsc_props.sv */
// Checker for the watchdog and system control ports
`timescale 1ns/10ps
`default_nettype none
module wdsc_props #(
    parameter logic [15:0] WDT_LAST = 16'hFFFF
) (
    input wire logic                    clk,
    input wire logic                    nrst,
    input wire wdsc_pkg::wdsc_sfr_req_t sfr_req,
    input wire logic [7:0]              sfr_rdata,
    input wire logic                    wdt_reset,
    input wire logic                    ale_clk,
    input wire logic [15:0]             wdt_count
);
    // ----
    // Properties
    // ----
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    logic wr_wdc;
    logic wr_sys;
    assign wr_wdc = sfr_req.wr && sfr_req.addr == 8'hD8;
    assign wr_sys = sfr_req.wr && sfr_req.addr == 8'hBF;
    a_reset_one_cycle: assert property (wdt_reset |=> !wdt_reset)
        else $error("watchdog reset longer than one cycle");
    a_overflow_cause: assert property (
        $rose(wdt_reset) |-> $past(wdt_count) == WDT_LAST)
        else $error("watchdog reset without a full count");
    a_count_bounded: assert property (wdt_count <= WDT_LAST)
        else $error("count beyond its last value");
    a_count_steps: assert property (
        !$stable(wdt_count) |->
        wdt_count == $past(wdt_count) + 16'h0001 || wdt_count == 16'h0000)
        else $error("count jumped");
    a_overflow_zeroes: assert property (
        wdt_reset |-> wdt_count == 16'h0000)
        else $error("count not zero at overflow");
    a_clear_restarts: assert property (
        wr_wdc && sfr_req.wdata[5] |=> wdt_count == 16'h0000)
        else $error("clear did not zero the count");
    a_emi_quiet: assert property (
        wr_sys && sfr_req.wdata[0] |=> ##1 !ale_clk [*4])
        else $error("strobe output while suppressed");
    a_ale_high_three: assert property (
        $rose(ale_clk) |-> ale_clk [*3] ##1 !ale_clk)
        else $error("strobe high phase not three cycles");
    a_wdc_unused_zero: assert property (
        sfr_req.rd && sfr_req.addr == 8'hD8 |=> (sfr_rdata & 8'h78) == 8'h00)
        else $error("watchdog control unused bits not zero");
    a_sys_unused_zero: assert property (
        sfr_req.rd && sfr_req.addr == 8'hBF |=> (sfr_rdata & 8'h7E) == 8'h00)
        else $error("system control unused bits not zero");
    cover property (wdt_reset);
    cover property (wr_wdc && sfr_req.wdata[5]);
    cover property ($fell(ale_clk));
endmodule // wdsc_props
bind wdsc_top wdsc_props #(.WDT_LAST(WDT_LAST)) u_props (.clk(clk),
    .nrst(nrst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .wdt_reset(wdt_reset), .ale_clk(ale_clk), .wdt_count(wdt_count));
`default_nettype wire

/* File: test/wdsc_top_bench.sv */
// Register-level tests of the watchdog and system control block
`timescale 1ns/10ps
`default_nettype none
module wdsc_top_bench;
    // ----
    // Harness
    // ----
    // Short last count keeps every divider code quick to overflow
    localparam logic [15:0] LAST = 16'h0003;
    logic                    clk;
    logic                    nrst;
    wdsc_pkg::wdsc_sfr_req_t req;
    logic [7:0]              rdata;
    logic                    wrst;
    logic                    ale;
    logic [15:0]             cnt;
    int                      bad_count;
    int                      n_compared;
    int                      n;
    int                      t_exp;
    wdsc_top #(.WDT_LAST(LAST)) DUT (.clk(clk), .nrst(nrst), .sfr_req(req),
        .sfr_rdata(rdata), .wdt_reset(wrst), .ale_clk(ale), .wdt_count(cnt));
    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req.addr = a;
        req.wdata = d;
        req.wr = 1'b1;
        @(negedge clk);
        req.wr = 1'b0;
        // One idle edge so back-to-back calls never re-raise a strobe
        @(negedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        req.addr = a;
        req.rd = 1'b1;
        @(negedge clk);
        req.rd = 1'b0;
        chk("sfr_rdata", {8'h00, exp}, {8'h00, rdata});
        @(negedge clk);
    endtask
    task automatic wait_rst(output int c);
        c = 0;
        while (wrst !== 1'b1 && c < 5000) begin
            @(negedge clk);
            c++;
        end
    endtask
    task automatic wait_ale(input logic v);
        for (int i = 0; i < 20 && ale !== v; i++) begin
            @(negedge clk);
        end
    endtask
    task automatic count_ale(output int c);
        c = 0;
        repeat (12) begin
            @(negedge clk);
            c += int'(ale === 1'b1);
        end
    endtask
    task automatic report_and_stop();
        if (bad_count == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ----
    // Stimulus
    // ----
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        #1500000;
        bad_count++;
        report_and_stop();
    end
    initial begin
        bad_count = 0;
        n_compared = 0;
        nrst = 1'b0;
        req = '0;
        repeat (2) @(negedge clk);
        nrst = 1'b1;
        // Pin reset lets go of the block two edges after release
        repeat (3) @(negedge clk);
        rd(8'hD8, 8'h00);
        rd(8'hBF, 8'h00);
        wr(8'h10, 8'hFF);
        rd(8'h10, 8'h00);
        repeat (40) @(negedge clk);
        chk("wdt_count", 16'h0000, cnt);
        for (int k = 0; k < 8; k++) begin
            wr(8'hD8, 8'h80 | 8'(k));
            rd(8'hD8, 8'h80 | 8'(k));
            t_exp = (int'(LAST) + 1) * (8 << k);
            wait_rst(n);
            chk("timeout", 16'h0001,
                16'(n >= t_exp - 4 && n <= t_exp + 12));
            @(negedge clk);
            rd(8'hD8, 8'h00);
            rd(8'hBF, 8'h80);
            wr(8'hBF, 8'hFE);
            rd(8'hBF, 8'h80);
            wr(8'hBF, 8'h00);
            rd(8'hBF, 8'h00);
        end
        wr(8'hD8, 8'h80);
        for (int k = 0; k < 6; k++) begin
            repeat (20) @(negedge clk);
            chk("wdt_count", 16'h0002, cnt);
            wr(8'hD8, 8'hA0);
            chk("wdt_count", 16'h0000, cnt);
        end
        rd(8'hD8, 8'h80);
        rd(8'hBF, 8'h00);
        nrst = 1'b0;
        @(negedge clk);
        nrst = 1'b1;
        repeat (3) @(negedge clk);
        rd(8'hD8, 8'h00);
        // Suppress only in a low phase so no high phase is cut short
        wait_ale(1'b1);
        wait_ale(1'b0);
        wr(8'hBF, 8'h01);
        rd(8'hBF, 8'h01);
        count_ale(n);
        chk("ale_high", 16'h0000, 16'(n));
        // Release mid low phase too, so the next high phase is whole
        @(negedge clk);
        wr(8'hBF, 8'h00);
        repeat (3) @(negedge clk);
        count_ale(n);
        chk("ale_high", 16'h0006, 16'(n));
        report_and_stop();
    end
endmodule // wdsc_top_bench
`default_nettype wire
